// ===== design/dsa_pkg.sv
package dsa_pkg;
  localparam int ALU_W = 54;
  localparam int A_W = 18;
  localparam int B_W = 36;
  localparam int NUM_CLK = 4;
  localparam int CLK_SEL_W = 2;
  localparam int RND_POS_W = 6;
  localparam logic [ALU_W-1:0] ACC_RESET = 54'h0;
  // register stage indices within the slice
  localparam int STG_IN = 0;
  localparam int STG_PIPE = 1;
  localparam int STG_OUT = 2;
  localparam int NUM_STG = 3;

  typedef enum logic [3:0] {
    DSA_OP_ADD = 4'h0,
    DSA_OP_SUB = 4'h1,
    DSA_OP_MAC = 4'h2,
    DSA_OP_AND = 4'h3,
    DSA_OP_OR = 4'h4,
    DSA_OP_NAND = 4'h5,
    DSA_OP_NOR = 4'h6,
    DSA_OP_XOR = 4'h7,
    DSA_OP_XNOR = 4'h8,
    DSA_OP_ADD3 = 4'h9
  } dsa_op_t;

  typedef enum logic [2:0] {
    DSA_RND_NONE = 3'h0,
    DSA_RND_ZERO = 3'h1,
    DSA_RND_INF = 3'h2,
    DSA_RND_DYN = 3'h3,
    DSA_RND_RAND = 3'h4,
    DSA_RND_CONV = 3'h5
  } dsa_rnd_t;

  typedef enum logic [1:0] {
    DSA_CSEL_C = 2'h0,
    DSA_CSEL_CASCADE = 2'h1,
    DSA_CSEL_ACC = 2'h2,
    DSA_CSEL_ZERO = 2'h3
  } dsa_csel_t;

  typedef struct packed {
    logic [CLK_SEL_W-1:0] clk_sel;
    logic [CLK_SEL_W-1:0] ce_sel;
    logic [CLK_SEL_W-1:0] rst_sel;
    logic async_rst;
  } dsa_stage_cfg_t;

  typedef struct packed {
    logic zero_match_flag;
    logic masked_zero_match_flag;
    logic masked_ones_match_flag;
    logic masked_pattern_match_flag;
    logic masked_inverse_pattern_match_flag;
    logic overflow_flag;
    logic underflow_flag;
    logic either_range_excess_flag;
  } dsa_flags_t;
endpackage : dsa_pkg

// ===== design/dsa_stage_reg.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_stage_reg #(
  parameter int W = 8
) (
  input wire logic [dsa_pkg::NUM_CLK-1:0] clk_src,
  input wire logic [dsa_pkg::NUM_CLK-1:0] ce_src,
  input wire logic [dsa_pkg::NUM_CLK-1:0] rst_src,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire dsa_pkg::dsa_stage_cfg_t cfg,
  input wire logic bypass,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import dsa_pkg::*;
  logic sel_clk;
  logic sel_ce;
  logic sel_rst;
  logic arst_n;
  logic [W-1:0] r;
  logic [W-1:0] next_r;

  assign sel_clk = clk_src[cfg.clk_sel];
  assign sel_ce = ce_src[cfg.ce_sel];
  assign sel_rst = rst_src[cfg.rst_sel];
  assign arst_n = reset_n & ~(cfg.async_rst & sel_rst);

  always_comb begin
    next_r = r;
    if (sel_rst && !cfg.async_rst) begin
      next_r = '0;
    end else if (sel_ce && clk_en) begin
      next_r = d;
    end
  end

  always_ff @(posedge sel_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = bypass ? d : r;
endmodule : dsa_stage_reg
`default_nettype wire

// ===== design/dsa_slice_alu.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_slice_alu #(
  parameter int W = dsa_pkg::ALU_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [dsa_pkg::NUM_CLK-1:0] clock_src,
  input wire logic [dsa_pkg::NUM_CLK-1:0] ce_src,
  input wire logic [dsa_pkg::NUM_CLK-1:0] rst_src,
  input wire dsa_pkg::dsa_stage_cfg_t in_cfg,
  input wire dsa_pkg::dsa_stage_cfg_t pipe_cfg,
  input wire dsa_pkg::dsa_stage_cfg_t out_cfg,
  input wire logic in_bypass,
  input wire logic pipe_bypass,
  input wire logic mult_bypass,
  input wire dsa_pkg::dsa_op_t opcode,
  input wire dsa_pkg::dsa_csel_t c_sel,
  input wire dsa_pkg::dsa_rnd_t round_mode,
  input wire logic [dsa_pkg::RND_POS_W-1:0] round_pos,
  input wire logic dyn_round_up,
  input wire logic acc_load,
  input wire logic signed [dsa_pkg::A_W-1:0] mul_a,
  input wire logic signed [dsa_pkg::B_W-1:0] mul_b,
  input wire logic [W-1:0] op_a,
  input wire logic [W-1:0] op_b,
  input wire logic [W-1:0] op_c,
  input wire logic [W-1:0] cascade_in,
  input wire logic [W-1:0] pattern,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] result,
  output logic [W-1:0] cascade_out,
  output dsa_pkg::dsa_flags_t flags
);
  import dsa_pkg::*;
  localparam int IN_W = dsa_pkg::A_W + dsa_pkg::B_W + 3 * W + 8;
  localparam int PIPE_W = 3 * W + 8;
  localparam int OUT_W = W + 8;

  logic [IN_W-1:0] in_d;
  logic [IN_W-1:0] in_q;
  logic signed [A_W-1:0] ra;
  logic signed [B_W-1:0] rb;
  logic [W-1:0] rx;
  logic [W-1:0] ry;
  logic [W-1:0] rc;
  logic [3:0] rop;
  logic [2:0] rrnd;
  logic rload;
  logic [PIPE_W-1:0] pipe_d;
  logic [PIPE_W-1:0] pipe_q;
  logic [W-1:0] px;
  logic [W-1:0] py;
  logic [W-1:0] pc;
  logic [3:0] pop;
  logic [2:0] prnd;
  logic pload;
  logic signed [A_W+B_W-1:0] product;
  logic [W-1:0] acc;
  logic [W-1:0] c_mux;
  logic [W:0] sum;
  logic [W-1:0] alu;
  logic [W-1:0] half;
  logic [W-1:0] lsb;
  logic [W-1:0] low_mask;
  logic round_add;
  logic [W-1:0] rounded;
  logic ovf;
  logic unf;
  logic [OUT_W-1:0] out_d;
  logic [OUT_W-1:0] out_q;
  logic [15:0] lfsr;
  logic [15:0] next_lfsr;

  function automatic logic masked_eq(input logic [W-1:0] v, input logic [W-1:0] p, input logic [W-1:0] m);
    masked_eq = ((v ^ p) & ~m) == '0;
  endfunction : masked_eq

  // input stage
  assign in_d = {mul_a, mul_b, op_a, op_b, op_c, 4'(opcode), 3'(round_mode), acc_load};
  dsa_stage_reg #(.W(IN_W)) u_in (
    .clk_src(clock_src), .ce_src(ce_src), .rst_src(rst_src), .reset_n(reset_n),
    .clk_en(clk_en), .cfg(in_cfg), .bypass(in_bypass), .d(in_d), .q(in_q)
  );
  assign {ra, rb, rx, ry, rc, rop, rrnd, rload} = in_q;

  // multiplier product or plain operand
  assign product = ra * rb;
  assign pipe_d = {mult_bypass ? rx : W'(product), ry, rc, rop, rrnd, rload};
  dsa_stage_reg #(.W(PIPE_W)) u_pipe (
    .clk_src(clock_src), .ce_src(ce_src), .rst_src(rst_src), .reset_n(reset_n),
    .clk_en(clk_en), .cfg(pipe_cfg), .bypass(pipe_bypass), .d(pipe_d), .q(pipe_q)
  );
  assign {px, py, pc, pop, prnd, pload} = pipe_q;

  assign acc = out_q[OUT_W-1:8];

  always_comb begin
    case (c_sel)
      DSA_CSEL_C: c_mux = pc;
      DSA_CSEL_CASCADE: c_mux = cascade_in;
      DSA_CSEL_ACC: c_mux = pload ? '0 : acc;
      default: c_mux = '0;
    endcase
  end

  always_comb begin
    sum = '0;
    alu = '0;
    ovf = 1'b0;
    unf = 1'b0;
    case (dsa_op_t'(pop))
      DSA_OP_ADD, DSA_OP_MAC: begin
        sum = {px[W-1], px} + {c_mux[W-1], c_mux};
        alu = sum[W-1:0];
        ovf = !px[W-1] && !c_mux[W-1] && sum[W-1];
        unf = px[W-1] && c_mux[W-1] && !sum[W-1];
      end
      DSA_OP_ADD3: begin
        sum = {px[W-1], px} + {py[W-1], py} + {c_mux[W-1], c_mux};
        alu = sum[W-1:0];
        ovf = !sum[W] && sum[W-1];
        unf = sum[W] && !sum[W-1];
      end
      DSA_OP_SUB: begin
        sum = {c_mux[W-1], c_mux} - {px[W-1], px};
        alu = sum[W-1:0];
        ovf = !c_mux[W-1] && px[W-1] && sum[W-1];
        unf = c_mux[W-1] && !px[W-1] && !sum[W-1];
      end
      DSA_OP_AND: alu = px & py;
      DSA_OP_OR: alu = px | py;
      DSA_OP_NAND: alu = ~(px & py);
      DSA_OP_NOR: alu = ~(px | py);
      DSA_OP_XOR: alu = px ^ py;
      DSA_OP_XNOR: alu = ~(px ^ py);
      default: alu = '0;
    endcase
  end

  // rounding: half an lsb (DYN, RAND, INF) or one retained lsb (ZERO, CONV) added, then low bits cleared
  always_comb begin
    lsb = W'(1) << round_pos;
    half = lsb >> 1;
    low_mask = lsb - W'(1);
    round_add = 1'b0;
    case (dsa_rnd_t'(prnd))
      DSA_RND_ZERO: round_add = alu[W-1] && ((alu & low_mask) != '0);
      DSA_RND_INF: round_add = !alu[W-1] || ((alu & half) != '0 && (alu & (low_mask >> 1)) != '0);
      DSA_RND_DYN: round_add = dyn_round_up;
      DSA_RND_RAND: round_add = lfsr[0];
      DSA_RND_CONV: round_add = (alu & half) != '0 && (((alu & (low_mask >> 1)) != '0) || ((alu & lsb) != '0));
      default: round_add = 1'b0;
    endcase
    if (prnd == 3'(DSA_RND_NONE) || round_pos == '0) begin
      rounded = alu;
    end else if (prnd == 3'(DSA_RND_DYN) || prnd == 3'(DSA_RND_RAND) || prnd == 3'(DSA_RND_INF)) begin
      rounded = (alu + (round_add ? half : '0)) & ~low_mask;
    end else begin
      rounded = (alu + (round_add ? lsb : '0)) & ~low_mask;
    end
  end

  // random rounding source
  always_comb begin
    next_lfsr = lfsr;
    if (clk_en) begin
      next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfsr <= 16'hACE1;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  always_comb begin
    out_d[OUT_W-1:8] = rounded;
    out_d[7] = rounded == '0;
    out_d[6] = masked_eq(rounded, '0, mask);
    out_d[5] = masked_eq(rounded, '1, mask);
    out_d[4] = masked_eq(rounded, pattern, mask);
    out_d[3] = masked_eq(rounded, ~pattern, mask);
    out_d[2] = ovf;
    out_d[1] = unf;
    out_d[0] = ovf | unf;
  end

  // output register always used so flags are registered
  dsa_stage_reg #(.W(OUT_W)) u_out (
    .clk_src(clock_src), .ce_src(ce_src), .rst_src(rst_src), .reset_n(reset_n),
    .clk_en(clk_en), .cfg(out_cfg), .bypass(1'b0), .d(out_d), .q(out_q)
  );

  assign result = out_q[OUT_W-1:8];
  assign cascade_out = out_q[OUT_W-1:8];
  assign flags = dsa_flags_t'(out_q[7:0]);
endmodule : dsa_slice_alu
`default_nettype wire

// ===== verification/dsa_slice_alu_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_slice_alu_checker
  import dsa_pkg::*;
#(
  parameter int W = dsa_pkg::ALU_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [dsa_pkg::NUM_CLK-1:0] rst_src,
  input wire logic [W-1:0] pattern,
  input wire logic [W-1:0] mask,
  input wire logic [W-1:0] result,
  input wire logic [W-1:0] cascade_out,
  input wire dsa_pkg::dsa_flags_t flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_zero_flag: assert property (
    $changed(result) && $past(rst_src) == '0 |-> flags.zero_match_flag == (result == '0))
    else $error("zero flag wrong");
  a_masked_zero: assert property (
    $changed(result) && $stable(mask) && $past(rst_src) == '0
    |-> flags.masked_zero_match_flag == ((result & ~mask) == '0))
    else $error("masked zero flag wrong");
  a_masked_ones: assert property (
    $changed(result) && $stable(mask) |-> flags.masked_ones_match_flag == ((result | mask) == '1))
    else $error("masked ones flag wrong");
  a_pattern_match: assert property (
    $changed(result) && $stable(mask) && $stable(pattern)
    |-> flags.masked_pattern_match_flag == (((result ^ pattern) & ~mask) == '0)) else $error("pattern flag wrong");
  a_inverse_match: assert property (
    $changed(result) && $stable(mask) && $stable(pattern)
    |-> flags.masked_inverse_pattern_match_flag == (((result ^ ~pattern) & ~mask) == '0))
    else $error("inverse pattern flag wrong");
  a_either_flag: assert property (
    flags.either_range_excess_flag == (flags.overflow_flag || flags.underflow_flag)) else $error("either flag wrong");
  a_range_exclusive: assert property (
    !(flags.overflow_flag && flags.underflow_flag)) else $error("over and under together");
  a_cascade_copy: assert property (
    cascade_out == result) else $error("cascade out differs");
  a_enable_freeze: assert property (
    !clk_en |=> $stable(result) && $stable(flags)) else $error("state moved while disabled");
endmodule : dsa_slice_alu_checker
bind dsa_slice_alu dsa_slice_alu_checker #(.W(W)) dsa_slice_alu_checker_inst (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .rst_src(rst_src), .pattern(pattern), .mask(mask), .result(result), .cascade_out(cascade_out),
  .flags(flags));
`default_nettype wire

// ===== verification/dsa_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_fabric_model
  import dsa_pkg::*;
(
  input wire logic clk,
  input wire logic [dsa_pkg::NUM_CLK-1:0] run,
  output logic [dsa_pkg::NUM_CLK-1:0] clock_src,
  output logic [dsa_pkg::NUM_CLK-1:0] ce_src
);
  // gated sources; run only changes while clk is low
  always_comb clock_src = {NUM_CLK{clk}} & run;
  always_comb ce_src = run;
endmodule : dsa_fabric_model
`default_nettype wire

// ===== verification/dsa_slice_alu_round_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module dsa_slice_alu_round_flags_tb;
  import dsa_pkg::*;
  logic clk, reset_n, clk_en, byp, mult_bypass, dyn_round_up, acc_load;
  logic [3:0] run, rst_src, clock_src, ce_src;
  dsa_stage_cfg_t cfg;
  dsa_op_t opcode;
  dsa_csel_t c_sel;
  dsa_rnd_t round_mode;
  logic [5:0] round_pos;
  logic signed [17:0] mul_a;
  logic signed [35:0] mul_b;
  logic [53:0] op_a, op_b, op_c, cascade_in, pattern, mask, result, cascade_out;
  dsa_flags_t flags;
  int miscompares, samples_checked, lat;
  logic [53:0] le[6] = '{54'hF, 54'hFFF, 54'h3FFFFFFFFFFFF0, 54'h3FFFFFFFFFF000, 54'hFF0, 54'h3FFFFFFFFFF00F};
  logic [2:0] rm[8] = '{0, 1, 2, 3, 5, 5, 4, 1};
  logic [53:0] rv[8] = '{54'h1C, 54'h1C, 54'h1C, 54'h1C, 54'h18, 54'h28, 54'h10, 54'h3FFFFFFFFFFFE4};
  logic [53:0] re[8] = '{54'h1C, 54'h10, 54'h20, 54'h20, 54'h20, 54'h20, 54'h10, 54'h3FFFFFFFFFFFF0};
  dsa_fabric_model dsa_fabric_model_inst (.clk, .run, .clock_src, .ce_src);
  dsa_slice_alu dsa_slice_alu_inst (.clk, .reset_n, .clk_en, .clock_src, .ce_src, .rst_src, .in_cfg(cfg),
    .pipe_cfg(cfg), .out_cfg(cfg), .in_bypass(byp), .pipe_bypass(byp), .mult_bypass, .opcode, .c_sel,
    .round_mode, .round_pos, .dyn_round_up, .acc_load, .mul_a, .mul_b, .op_a, .op_b, .op_c, .cascade_in,
    .pattern, .mask, .result, .cascade_out, .flags);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // drive at a falling edge, look once the answer has landed
  task automatic go(dsa_op_t o, logic [53:0] a, logic [53:0] b, logic [53:0] e, string nm);
    opcode = o;
    op_a = a;
    op_b = b;
    repeat (lat) @(posedge clk);
    @(negedge clk);
    `CHK(nm, e, result)
  endtask : go
  initial begin
    reset_n = 0; clk_en = 1; byp = 0; lat = 3; mult_bypass = 1; dyn_round_up = 1; acc_load = 0;
    run = 4'h4; rst_src = 4'h0; cfg = '{2'h2, 2'h2, 2'h1, 1'b0}; opcode = DSA_OP_ADD; c_sel = DSA_CSEL_ZERO;
    round_mode = DSA_RND_NONE; round_pos = 6'h0; mul_a = -18'sh3; mul_b = 36'sh5;
    op_a = 0; op_b = 0; op_c = 54'h5; cascade_in = 54'h7; pattern = 54'h1C; mask = 54'h3;
    repeat (12) @(negedge clk);
    reset_n = 1;
    go(DSA_OP_ADD3, 54'h1FFFFFFFFFFFFF, 54'h1, 54'h20000000000000, "over sum");
    `CHK("over", 2'b11, {flags.overflow_flag, flags.either_range_excess_flag})
    go(DSA_OP_ADD3, 54'h20000000000000, 54'h3FFFFFFFFFFFFF, 54'h1FFFFFFFFFFFFF, "under sum");
    `CHK("under", 3'b011, {flags.overflow_flag, flags.underflow_flag, flags.either_range_excess_flag})
    c_sel = DSA_CSEL_C;
    go(DSA_OP_SUB, 54'h7, 54'h7, 54'h3FFFFFFFFFFFFE, "sub");
    go(DSA_OP_SUB, 54'h5, 54'h7, 54'h0, "sub zero");
    `CHK("zero", 1'b1, flags.zero_match_flag)
    for (int i = 0; i < 6; i++) go(dsa_op_t'(i + 3), 54'hF0F, 54'hFF, le[i], "logic");
    c_sel = DSA_CSEL_C;
    go(DSA_OP_ADD3, 54'h1, 54'h2, 54'h8, "add3 c");
    c_sel = DSA_CSEL_CASCADE;
    go(DSA_OP_ADD3, 54'h1, 54'h2, 54'hA, "add3 cascade");
    `CHK("cascade", 54'hA, cascade_out)
    c_sel = DSA_CSEL_ZERO;
    mult_bypass = 0;
    go(DSA_OP_ADD, 54'h9, 54'h0, 54'h3FFFFFFFFFFFF1, "product");
    mult_bypass = 1;
    go(DSA_OP_ADD, 54'h1C, 54'h0, 54'h1C, "pattern sum");
    `CHK("pattern", 1'b1, flags.masked_pattern_match_flag)
    go(DSA_OP_ADD, ~54'h1C, 54'h0, ~54'h1C, "inverse sum");
    `CHK("inverse", 1'b1, flags.masked_inverse_pattern_match_flag)
    round_pos = 6'h4;
    for (int i = 0; i < 8; i++) begin
      round_mode = dsa_rnd_t'(rm[i]);
      go(DSA_OP_ADD, rv[i], 54'h0, re[i], "round");
    end
    round_mode = DSA_RND_NONE;
    round_pos = 6'h0;
    op_a = 54'h55;
    clk_en = 0;
    repeat (4) @(negedge clk);
    `CHK("frozen", 54'h3FFFFFFFFFFFF0, result)
    clk_en = 1;
    go(DSA_OP_ADD, 54'h55, 54'h0, 54'h55, "thaw");
    rst_src = 4'h2;
    repeat (2) @(negedge clk);
    `CHK("sync clear", 54'h0, result)
    rst_src = 4'h0;
    byp = 1;
    lat = 1;
    go(DSA_OP_ADD3, 54'h30, 54'h4, 54'h34, "bypass");
    results();
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : dsa_slice_alu_round_flags_tb
`default_nettype wire
